// ---- qr_flyback_consts.vh ----
// Timing constants for the quasi-resonant switching-cycle sequencer
`ifndef QR_FLYBACK_CONSTS_VH
`define QR_FLYBACK_CONSTS_VH
`define CLK_HZ          10000000
`define SOFTSTART_US    4000
`define STARTUP_TOUT_US 100
`define STEADY_TOUT_US  6
`define MAX_DEAD_US     32
`define FMIN_PERIOD_US  40
`define QUIET_US        1250
`define FREQ_LIMIT_PIN_PERIOD_NS  9091
`define LEB_NS          275
`define JITTER_HZ       1300
`define BURST_PULSES    3
`define MAX_VALLEY      6
`endif

// ---- qr_flyback_switch_cycle_ctrl.v ----
// Switching-cycle sequencer of a quasi-resonant flyback controller
// Behaviour
// - Soft-start ramp limits peak setpoint over 4ms
// - Use 100us valley timeout during soft-start
// - Add triangular 1.3kHz jitter to current sense
// - Jitter has no effect in foldback mode
// - Max-frequency clamp disabled or fixed 110kHz
// - Limit pin above 4V disables clamp
// - Count valleys; switch at selected valley
// - Valley locked; hysteretic step up or down
// - Falling feedback thresholds advance the valley
// - Rising feedback thresholds step valley back
// - 6us timeout substitutes for missing valley
// - Timeout reruns per missing valley, then drive
// - Sixth valley below 0.8V freezes, enters foldback
// - Foldback adds dead time up to 32us
// - Force cycle at 40us, only after demagnetization
// - Stop pulses below skip, resume above hysteresis
// - Finish pulse in progress on skip entry
// - Skip exit restarts quiet timer, pulse counter
// - Stop burst only after three pulses counted
// - In burst, no restart before quiet timer expires
// - Quiet expiry alone never starts a burst
// - Feedback above 1V leaves burst immediately
// - Demag below trigger level is a valley
// - Blank current sense 275ns after turn-on
`timescale 1ns/100ps
`include "qr_flyback_consts.vh"
module qr_flyback_switch_cycle_ctrl #(
	parameter SOFTSTART_CYC = (`SOFTSTART_US * (`CLK_HZ / 1000000)),
	parameter QUIET_CYC     = (`QUIET_US * (`CLK_HZ / 1000000)),
	parameter FREQ_LIMIT_PIN_FIXED_EN = 1'b1,
	parameter REF_W         = 8
) (
	// Clock and reset
	input  wire             CLK,
	input  wire             RST_N,
	// Comparator results
	input  wire             DEMAG_SENSE,
	input  wire [2:0]       FB_VALLEY_DN,
	input  wire [2:0]       FB_VALLEY_UP,
	input  wire             FB_FOLDBACK,
	input  wire [REF_W-1:0] FB_DEAD_LEVEL,
	input  wire             FB_SKIP_IN,
	input  wire             FB_SKIP_OUT,
	input  wire             FB_BURST_EXIT,
	input  wire             PEAK_REACHED,
	input  wire             FREQ_LIMIT_PIN_HIGH,
	// Outputs
	output reg              GATE_DRIVE_OUT,
	output reg  [REF_W-1:0] SOFTSTART_REF,
	output reg  [REF_W-1:0] JITTER_LEVEL,
	output reg              FREQ_FOLDBACK,
	output reg  [2:0]       VALLEY_SEL
);
	localparam integer CPU = `CLK_HZ / 1000000;
	localparam integer TOUT1_CYC = `STARTUP_TOUT_US * CPU;
	localparam integer TOUT2_CYC = `STEADY_TOUT_US * CPU;
	localparam integer DEAD_CYC  = `MAX_DEAD_US * CPU;
	localparam integer FMIN_CYC  = `FMIN_PERIOD_US * CPU;
	localparam integer FREQ_LIMIT_PIN_CYC  = (`FREQ_LIMIT_PIN_PERIOD_NS * CPU + 999) / 1000;
	localparam integer LEB_CYC   = (`LEB_NS * CPU + 999) / 1000;
	localparam integer JIT_STEP  = `CLK_HZ / (`JITTER_HZ * 2 * (1 << REF_W));
	localparam integer SS_STEP   = SOFTSTART_CYC / (1 << REF_W);
	localparam [1:0] S_ON = 2'd0, S_DEMAG = 2'd1, S_WAIT = 2'd2, S_DEAD = 2'd3;

	// Synchronised comparator inputs
	reg [2:0] dn_r, up_r;
	reg       demag_r, ff_r, skin_r, skout_r, bexit_r, peak_r, fpin_r;
	reg [REF_W-1:0] dlev_r;
	always @(posedge CLK) begin
		dn_r    <= FB_VALLEY_DN;
		up_r    <= FB_VALLEY_UP;
		demag_r <= DEMAG_SENSE;
		ff_r    <= FB_FOLDBACK;
		skin_r  <= FB_SKIP_IN;
		skout_r <= FB_SKIP_OUT;
		bexit_r <= FB_BURST_EXIT;
		peak_r  <= PEAK_REACHED;
		fpin_r  <= FREQ_LIMIT_PIN_HIGH;
		dlev_r  <= FB_DEAD_LEVEL;
	end

	reg [1:0]  st_r;
	reg [15:0] tmr_r, per_r, ss_r, quiet_r, jdiv_r;
	reg [2:0]  vcnt_r;
	reg [1:0]  pcnt_r;
	reg        ss_done_r, demag_prev_r, jdir_r, burst_r, halt_r;

	wire valley   = demag_prev_r & ~demag_r;
	wire [15:0] tout = ss_done_r ? TOUT2_CYC[15:0] : TOUT1_CYC[15:0];
	wire freq_limit_pin_en  = FREQ_LIMIT_PIN_FIXED_EN & ~fpin_r;
	wire [31:0] dead_full = (DEAD_CYC * dlev_r) >> REF_W;
	wire [15:0] dead      = dead_full[15:0];
	// The minimum-frequency force never fires while the winding still demagnetizes
	wire fmin_due = (per_r >= FMIN_CYC[15:0]) & ~demag_r;
	wire quiet_done = (quiet_r == 16'h0000);

	// Selects whether a pulse may start this cycle
	function may_fire;
		input h;
		input [15:0] per;
		input fe;
		begin
			may_fire = ~h & (~fe | per >= FREQ_LIMIT_PIN_CYC[15:0]);
		end
	endfunction

	always @(posedge CLK) begin
		if (!RST_N) begin
			st_r <= S_DEMAG;
			tmr_r <= 16'h0000;
			per_r <= 16'h0000;
			ss_r <= 16'h0000;
			quiet_r <= 16'h0000;
			jdiv_r <= 16'h0000;
			vcnt_r <= 3'd0;
			pcnt_r <= 2'd0;
			ss_done_r <= 1'b0;
			demag_prev_r <= 1'b0;
			jdir_r <= 1'b0;
			burst_r <= 1'b0;
			halt_r <= 1'b0;
			GATE_DRIVE_OUT <= 1'b0;
			SOFTSTART_REF <= {REF_W{1'b0}};
			JITTER_LEVEL <= {REF_W{1'b0}};
			FREQ_FOLDBACK <= 1'b0;
			VALLEY_SEL <= 3'd1;
		end else begin
			demag_prev_r <= demag_r;
			// Soft-start ramp from zero
			if (!ss_done_r) begin
				if (ss_r >= SS_STEP[15:0] - 16'h0001) begin
					ss_r <= 16'h0000;
					if (&SOFTSTART_REF)
						ss_done_r <= 1'b1;
					else
						SOFTSTART_REF <= SOFTSTART_REF + 1'b1;
				end else begin
					ss_r <= ss_r + 16'h0001;
				end
			end
			// Triangle jitter, held at zero in foldback
			if (jdiv_r >= JIT_STEP[15:0] - 16'h0001) begin
				jdiv_r <= 16'h0000;
				if (FREQ_FOLDBACK)
					JITTER_LEVEL <= {REF_W{1'b0}};
				else if (!jdir_r) begin
					JITTER_LEVEL <= JITTER_LEVEL + 1'b1;
					if (JITTER_LEVEL == {{(REF_W-1){1'b1}}, 1'b0})
						jdir_r <= 1'b1;
				end else begin
					JITTER_LEVEL <= JITTER_LEVEL - 1'b1;
					if (JITTER_LEVEL == {{(REF_W-1){1'b0}}, 1'b1})
						jdir_r <= 1'b0;
				end
			end else begin
				jdiv_r <= jdiv_r + 16'h0001;
			end
			// Valley selection with lockout hysteresis
			if (VALLEY_SEL < `MAX_VALLEY && dn_r >= VALLEY_SEL)
				VALLEY_SEL <= VALLEY_SEL + 3'd1;
			else if (VALLEY_SEL > 3'd1 && up_r >= VALLEY_SEL - 3'd1)
				VALLEY_SEL <= VALLEY_SEL - 3'd1;
			FREQ_FOLDBACK <= (VALLEY_SEL == `MAX_VALLEY) & ff_r & ~(up_r >= 3'd5);
			// Decrement first so that a reload below takes precedence
			if (!quiet_done)
				quiet_r <= quiet_r - 16'h0001;
			// Skip and burst control
			if (bexit_r) begin
				burst_r <= 1'b0;
				halt_r <= 1'b0;
			end else if (halt_r) begin
				if (skout_r && (quiet_done || !burst_r)) begin
					halt_r <= 1'b0;
					burst_r <= 1'b1;
					quiet_r <= QUIET_CYC[15:0];
					pcnt_r <= 2'd0;
				end
			end else if (skin_r && st_r != S_ON &&
				(!burst_r || pcnt_r == `BURST_PULSES)) begin
				halt_r <= 1'b1;
			end
			per_r <= (per_r == 16'hffff) ? per_r : per_r + 16'h0001;
			tmr_r <= tmr_r + 16'h0001;
			// Switching cycle
			case (st_r)
				S_ON: begin
					if (tmr_r >= LEB_CYC[15:0] && peak_r) begin
						GATE_DRIVE_OUT <= 1'b0;
						st_r <= S_DEMAG;
						tmr_r <= 16'h0000;
					end
				end
				S_DEMAG: begin
					if (demag_r || tmr_r >= tout) begin
						st_r <= S_WAIT;
						vcnt_r <= 3'd0;
						tmr_r <= 16'h0000;
					end
				end
				S_WAIT: begin
					if (valley || tmr_r >= tout || fmin_due) begin
						tmr_r <= 16'h0000;
						if (vcnt_r + 3'd1 >= VALLEY_SEL || fmin_due) begin
							st_r <= S_DEAD;
						end else begin
							vcnt_r <= vcnt_r + 3'd1;
						end
					end
				end
				S_DEAD: begin
					if ((!FREQ_FOLDBACK || tmr_r >= dead || per_r >= FMIN_CYC[15:0]) &&
						may_fire(halt_r, per_r, freq_limit_pin_en)) begin
						GATE_DRIVE_OUT <= 1'b1;
						st_r <= S_ON;
						tmr_r <= 16'h0000;
						per_r <= 16'h0000;
						if (burst_r && pcnt_r != `BURST_PULSES)
							pcnt_r <= pcnt_r + 2'd1;
					end
				end
				default: st_r <= S_DEMAG;
			endcase
		end
	end
endmodule

// ---- qr_cycle_chk_asserts.sv ----
// Port assertions for the switching-cycle sequencer
`timescale 1ns/100ps
module qr_cycle_chk #(parameter REF_W = 8) (
	input wire             CLK,
	input wire             RST_N,
	input wire [2:0]       FB_VALLEY_DN,
	input wire             PEAK_REACHED,
	input wire             GATE_DRIVE_OUT,
	input wire [REF_W-1:0] SOFTSTART_REF,
	input wire             FREQ_FOLDBACK,
	input wire [2:0]       VALLEY_SEL
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	a_reset_clears_outs: assert property (disable iff (1'b0) !RST_N |=> !GATE_DRIVE_OUT && SOFTSTART_REF == 0
		&& !FREQ_FOLDBACK && VALLEY_SEL == 3'h1) else $error("outputs not cleared");
	a_valley_in_range: assert property (VALLEY_SEL >= 3'h1 && VALLEY_SEL <= 3'h6) else $error("valley range");
	a_valley_one_step: assert property ($changed(VALLEY_SEL) |-> VALLEY_SEL == $past(VALLEY_SEL) + 3'h1
		|| VALLEY_SEL == $past(VALLEY_SEL) - 3'h1) else $error("valley jump");
	a_advance_needs_fb: assert property (VALLEY_SEL == $past(VALLEY_SEL) + 3'h1
		|-> $past(FB_VALLEY_DN, 2) >= $past(VALLEY_SEL)) else $error("valley advance without cause");
	a_blank_holds_gate: assert property ($rose(GATE_DRIVE_OUT) |=> GATE_DRIVE_OUT [*2]) else $error("on-time cut");
	a_peak_ends_on: assert property (GATE_DRIVE_OUT [*4] ##0 PEAK_REACHED |-> ##[1:3] !GATE_DRIVE_OUT)
		else $error("gate not ended by peak");
	a_ramp_never_falls: assert property ($past(RST_N) |-> SOFTSTART_REF >= $past(SOFTSTART_REF))
		else $error("ramp fell");
	a_fold_at_sixth: assert property ($rose(FREQ_FOLDBACK) |-> VALLEY_SEL == 3'h6) else $error("early foldback");
	c_pulse: cover property ($rose(GATE_DRIVE_OUT));
	c_sixth: cover property (VALLEY_SEL == 3'h6);
	c_fold: cover property ($rose(FREQ_FOLDBACK));
endmodule
bind qr_flyback_switch_cycle_ctrl qr_cycle_chk #(.REF_W(REF_W)) chk (.CLK(CLK), .RST_N(RST_N),
	.FB_VALLEY_DN(FB_VALLEY_DN), .PEAK_REACHED(PEAK_REACHED), .GATE_DRIVE_OUT(GATE_DRIVE_OUT),
	.SOFTSTART_REF(SOFTSTART_REF), .FREQ_FOLDBACK(FREQ_FOLDBACK), .VALLEY_SEL(VALLEY_SEL));

// ---- flyback_power_stage.sv ----
// Behavioural power switch and auxiliary winding
`timescale 1ns/100ps
module flyback_power_stage (
	input  wire       clk,
	input  wire       gate,
	input  wire [7:0] on_len,
	input  wire [7:0] dm_len,
	output reg        peak,
	output reg        demag
);
	integer t = 0;
	reg     gate_d = 1'b0;
	initial begin
		peak = 1'b0;
		demag = 1'b0;
	end
	// Four ring periods after demagnetization, then too damped to detect
	always @(posedge clk) begin
		#1;
		t = (gate != gate_d) ? 0 : t + 1;
		gate_d = gate;
		peak = gate && t >= on_len;
		demag = !gate && (t < dm_len || (t < dm_len + 40 && t % 10 < 5));
	end
endmodule

// ---- tb.sv ----
// Self-checking testbench for the switching-cycle sequencer
`timescale 1ns/100ps
module tb;
	reg        clk = 1'b0, rst_n = 1'b0, fold = 1'b0, s_in = 1'b0, s_out = 1'b1, b_ex = 1'b1, fpin = 1'b0;
	reg  [2:0] dn = 3'h0, up = 3'h0, v = 3'h1;
	reg  [7:0] dead = 8'h00, on_len = 8'd10, dm_len = 8'd20;
	wire       gate, peak, demag, ffb;
	wire [7:0] ssr, jit;
	wire [2:0] vsel;
	integer    seed = 68540, errors = 0, cmp_count = 0, rises = 0, i;
	always #50 clk = ~clk;
	always @(posedge gate) rises = rises + 1;
	qr_flyback_switch_cycle_ctrl #(.SOFTSTART_CYC(512), .QUIET_CYC(8000)) dut (.CLK(clk), .RST_N(rst_n),
		.DEMAG_SENSE(demag), .FB_VALLEY_DN(dn), .FB_VALLEY_UP(up), .FB_FOLDBACK(fold), .FB_DEAD_LEVEL(dead),
		.FB_SKIP_IN(s_in), .FB_SKIP_OUT(s_out), .FB_BURST_EXIT(b_ex), .PEAK_REACHED(peak),
		.FREQ_LIMIT_PIN_HIGH(fpin), .GATE_DRIVE_OUT(gate), .SOFTSTART_REF(ssr), .JITTER_LEVEL(jit),
		.FREQ_FOLDBACK(ffb), .VALLEY_SEL(vsel));
	flyback_power_stage ps (.clk(clk), .gate(gate), .on_len(on_len), .dm_len(dm_len), .peak(peak), .demag(demag));
	task chk(input [7:0] got, input [7:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task cyc(input integer n);
		begin
			repeat (n) @(posedge clk);
			#1;
		end
	endtask
	// Valley the lockout should settle on for steady comparator inputs
	function [2:0] settle(input [2:0] s, input [2:0] d, input [2:0] u);
		begin
			settle = s;
			repeat (6) begin
				if (d >= settle && settle < 3'h6) settle = settle + 3'h1;
				else if (settle > 3'h1 && u >= settle - 3'h1) settle = settle - 3'h1;
			end
		end
	endfunction
	task summarize;
		begin
			$display("errors %0d comparisons %0d", errors, cmp_count);
			if (errors == 0 && cmp_count > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	initial begin
		#(100 * 80000);
		errors = errors + 1;
		summarize;
	end
	initial begin
		cyc(12);
		chk({5'h0, vsel}, 8'h01);
		chk(ssr, 8'h00);
		rst_n = 1'b1;
		cyc(300);
		chk({7'h0, ssr != 0}, 8'h01);
		chk({7'h0, jit != 0}, 8'h01);
		for (i = 0; i < 8; i = i + 1) begin
			dn = (i == 0) ? 3'h5 : (i[0] ? 3'h0 : {$random(seed)} % 6);
			up = i[0] ? ((i == 1) ? 3'h5 : {$random(seed)} % 6) : 3'h0;
			on_len = 8'd5 + {$random(seed)} % 36;
			dm_len = 8'd10 + {$random(seed)} % 50;
			cyc(3000);
			v = settle(v, dn, up);
			chk({5'h0, vsel}, {5'h0, v});
		end
		{dn, up, fold, dead} = {3'h5, 3'h0, 1'b1, 8'hff};
		cyc(3000);
		chk({7'h0, ffb}, 8'h01);
		chk(jit, 8'h00);
		rises = 0;
		cyc(4000);
		chk({7'h0, rises >= 9}, 8'h01);
		{dn, up, fold, on_len, dm_len} = {3'h0, 3'h5, 1'b0, 8'd5, 8'd10};
		cyc(2000);
		rises = 0;
		cyc(4000);
		chk({7'h0, rises <= 44}, 8'h01);
		fpin = 1'b1;
		rises = 0;
		cyc(4000);
		chk({7'h0, rises > 44}, 8'h01);
		{s_in, s_out, b_ex} = 3'b100;
		cyc(200);
		rises = 0;
		cyc(2000);
		chk(rises[7:0], 8'h00);
		{s_in, s_out} = 2'b01;
		wait (rises == 1);
		cyc(1);
		{s_in, s_out} = 2'b10;
		cyc(3000);
		chk(rises[7:0], 8'h03);
		{s_in, s_out} = 2'b01;
		rises = 0;
		cyc(1000);
		chk(rises[7:0], 8'h00);
		b_ex = 1'b1;
		cyc(500);
		chk({7'h0, rises > 0}, 8'h01);
		summarize;
	end
endmodule
